/* File: hdl/dti_pkg.sv */
// Constants, register map and carrier types for the serial target interface
package dti_pkg;

    // Target address parts
    localparam logic [4:0] ADDR_FIXED = 5'h12;   // Fixed upper address bits 10010
    localparam logic [6:0] ADDR_BCAST = 7'h47;   // Broadcast write address 1000111
    localparam logic [6:0] ADDR_GCALL = 7'h00;   // General call address
    localparam logic [7:0] GC_RST_BYTE = 8'h06;  // General call reset code

    // Command byte register addresses
    localparam logic [7:0] CMD_OPER = 8'h01;     // pmbus_operation_cmd
    localparam logic [7:0] CMD_CODE = 8'h21;     // output_code
    localparam logic [7:0] CMD_MHI = 8'h25;      // upper_margin_code
    localparam logic [7:0] CMD_MLO = 8'h26;      // lower_margin_code
    localparam logic [7:0] CMD_PSTAT = 8'h78;    // pmbus_status_summary
    localparam logic [7:0] CMD_PREV = 8'h98;     // pmbus_revision
    localparam logic [7:0] CMD_FLAGS = 8'hD0;    // device_state_flags
    localparam logic [7:0] CMD_MAIN = 8'hD1;     // main_settings
    localparam logic [7:0] CMD_SEC = 8'hD2;      // secondary_settings
    localparam logic [7:0] CMD_ACT = 8'hD3;      // action_strobes

    // Field positions
    localparam int SEC_TADDR_HI = 15;            // Target address field
    localparam int SEC_TADDR_LO = 14;
    localparam int SEC_PINFN_HI = 13;            // input_pin_function field
    localparam int SEC_PINFN_LO = 11;
    localparam int ACT_PINEN = 10;               // input_pin_enable bit
    localparam logic [2:0] PINFN_ADDR = 3'h7;    // Function code for address assignment

    // Bit counter codes
    localparam logic [3:0] BIT_FIRST = 4'h0;     // First bit of a byte
    localparam logic [3:0] BIT_LAST = 4'h7;      // Eighth bit of a byte
    localparam logic [3:0] BIT_ACK = 4'h8;       // Acknowledge slot
    localparam logic [3:0] BIT_WAIT = 4'hF;      // Waiting for the start's own clock fall
    localparam logic [3:0] BIT_STEP = 4'h1;

    // Reset values
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [2:0] PINS_IDLE = 3'h6;     // Clock high, data high, pin low

    // Protocol states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_CMD = 7'h04,
        ST_DHI = 7'h08,
        ST_DLO = 7'h10,
        ST_TX = 7'h20,
        ST_SKIP = 7'h40
    } dti_state_type;

    // Writable register set
    typedef struct packed {
        logic [15:0] oper;
        logic [15:0] code;
        logic [15:0] mhi;
        logic [15:0] mlo;
        logic [15:0] main;
        logic [15:0] sec;
        logic [15:0] act;
    } dti_regs_type;

    // Read-only words supplied by the rest of the device
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] stat_sum;
        logic [15:0] revision;
    } dti_ro_type;

    // Pin samples
    typedef struct packed {
        logic scl;
        logic sda;
        logic pin;
    } dti_pins_type;

    localparam dti_regs_type REGS_RST = '0;

    // Whole protocol engine state
    typedef struct packed {
        dti_state_type st;
        dti_state_type nxt;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic [7:0] hi;
        logic [7:0] txsh;
        logic [7:0] txlo;
        logic [7:0] cmd;
        logic [7:0] last_wr;
        logic cmd_seen;
        logic bc;
        logic gc;
        logic lo_sent;
        logic mack;
        logic scl_p;
        logic sda_p;
        logic oe;
        logic upd;
        logic swrst;
        dti_regs_type regs;
    } dti_core_type;

    localparam dti_core_type CORE_RST = '{
        st: ST_IDLE, nxt: ST_IDLE, bitc: BIT_WAIT, scl_p: 1'h1, sda_p: 1'h1,
        regs: REGS_RST, default: '0};

endpackage

/* File: hdl/dti_sync.sv */
// Two-stage synchroniser for the serial pins and the general input pin
`timescale 1ns/100ps
module dti_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Raw and synchronised pins
    input wire dti_pkg::dti_pins_type pins_i,
    output dti_pkg::dti_pins_type pins_o
);
    import dti_pkg::*;

    // Both stages in one state word
    typedef struct packed {
        dti_pins_type meta;
        dti_pins_type sync;
    } dti_sync_type;

    dti_sync_type q;
    dti_sync_type d;

    // First stage feeds only the second
    always_comb begin
        d.meta = pins_i;
        d.sync = q.meta;
    end

    // Reset to the idle bus levels
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= {PINS_IDLE, PINS_IDLE};
        end else begin
            q <= d;
        end
    end

    assign pins_o = q.sync;
endmodule

/* File: hdl/dti_target.sv */
// Serial target engine: addressing, register writes, reads and general call reset
// What this block does
// - Write frame: address, command, two data bytes
// - Acknowledge each received byte, low through ninth clock
// - Single update takes 36 clocks after start
// - Upper byte then lower byte; update after both
// - Apply value on fall ending lower-byte acknowledge
// - Stop releases bus; idle until next start
// - Address upper five bits fixed at 10010
// - Two low address bits from target field
// - Accept broadcast write address regardless of field
// - Broadcast address never answered for reads
// - Gated broadcast settings write needs pin high
// - Command byte selects register by address
// - Read: write address, command, restart, read
// - Read without command returns last written register
// - General call reset at acknowledge rise
// - Only seven-bit addresses recognised
`timescale 1ns/100ps
module dti_target (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // Serial bus, open drain data
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // General input pin
    input wire logic GENERAL_INPUT_PIN_I,
    // Read-only words from the device
    input wire dti_pkg::dti_ro_type READBACK_I,
    // Register contents and events
    output dti_pkg::dti_regs_type REGS_O,
    output logic UPDATE_O,
    output logic SW_RESET_O
);
    import dti_pkg::*;

    dti_pins_type raw_pins;     // Pins as they arrive
    dti_pins_type pins;         // Pins after synchronisation
    dti_core_type q;            // Registered engine state
    dti_core_type d;            // Next engine state
    logic scl_rise;             // Clock edge seen this cycle
    logic scl_fall;
    logic start_seen;           // Data falls while clock high
    logic stop_seen;            // Data rises while clock high
    logic own_match;            // Address decode results
    logic bc_match;
    logic gc_match;
    logic pin_gate;             // Address assignment gate active and pin low
    logic [15:0] wr_word;       // Word assembled from the two data bytes
    logic [15:0] rd_word;       // Word chosen for a read

    assign raw_pins = '{scl: SCL_I, sda: SDA_I, pin: GENERAL_INPUT_PIN_I};

    // Pins cross into the clock domain here
    dti_sync u_sync (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .pins_i(raw_pins),
        .pins_o(pins)
    );

    // Edge and condition detection on synchronised pins
    assign scl_rise = pins.scl && !q.scl_p;
    assign scl_fall = !pins.scl && q.scl_p;
    assign start_seen = pins.scl && q.scl_p && q.sda_p && !pins.sda;
    assign stop_seen = pins.scl && q.scl_p && !q.sda_p && pins.sda;

    // Register lookup for reads; unknown commands read as zero
    function automatic logic [15:0] read_reg(
        input logic [7:0] cmd,
        input dti_regs_type regs,
        input dti_ro_type ro
    );
        logic [15:0] w;
        w = WORD_ZERO;
        case (cmd)
            CMD_OPER: w = regs.oper;
            CMD_CODE: w = regs.code;
            CMD_MHI: w = regs.mhi;
            CMD_MLO: w = regs.mlo;
            CMD_MAIN: w = regs.main;
            CMD_SEC: w = regs.sec;
            CMD_ACT: w = regs.act;
            CMD_FLAGS: w = ro.flags;
            CMD_PSTAT: w = ro.stat_sum;
            CMD_PREV: w = ro.revision;
            default: w = WORD_ZERO;
        endcase
        return w;
    endfunction

    // Address decode from the received address byte
    always_comb begin
        own_match = (q.sh[7:1] == {ADDR_FIXED, q.regs.sec[SEC_TADDR_HI:SEC_TADDR_LO]});
        bc_match = (q.sh[7:1] == ADDR_BCAST) && !q.sh[0];
        gc_match = (q.sh[7:1] == ADDR_GCALL) && !q.sh[0];
        pin_gate = (q.regs.sec[SEC_PINFN_HI:SEC_PINFN_LO] == PINFN_ADDR)
            && q.regs.act[ACT_PINEN] && q.bc && !pins.pin;
        wr_word = {q.hi, q.sh};
        // No command this transaction: fall back to the last written register
        rd_word = read_reg(q.cmd_seen ? q.cmd : q.last_wr, q.regs, READBACK_I);
    end

    // Protocol engine next state
    always_comb begin
        d = q;
        d.upd = 1'h0;
        d.swrst = 1'h0;
        d.scl_p = pins.scl;
        d.sda_p = pins.sda;
        if (start_seen) begin
            // Start or repeated start; command pointer survives a restart
            d.st = ST_ADDR;
            d.bitc = BIT_WAIT;
            d.oe = 1'h0;
            d.bc = 1'h0;
            d.gc = 1'h0;
        end else if (stop_seen) begin
            // Release the line and wait for a start
            d.st = ST_IDLE;
            d.oe = 1'h0;
            d.cmd_seen = 1'h0;
        end else if (scl_rise) begin
            // Data bits are taken while the clock is high
            if (q.bitc <= BIT_LAST) begin
                d.sh = {q.sh[6:0], pins.sda};
            end
            // Controller answer to a byte we sent
            if (q.st == ST_TX && q.bitc == BIT_ACK) begin
                d.mack = !pins.sda;
            end
            // Reset fires on the rising clock of our reset-byte acknowledge
            if (q.gc && q.st == ST_CMD && q.bitc == BIT_ACK && q.oe) begin
                d.swrst = 1'h1;
                d.regs = REGS_RST;
            end
        end else if (scl_fall && q.st != ST_IDLE && q.st != ST_SKIP) begin
            if (q.bitc == BIT_WAIT) begin
                // Fall belonging to the start itself
                d.bitc = BIT_FIRST;
            end else if (q.bitc == BIT_LAST) begin
                // Eight bits done: enter the ninth clock
                d.bitc = BIT_ACK;
                unique case (q.st)
                    ST_ADDR: begin
                        // Ten-bit headers never match and are left alone
                        d.oe = own_match || bc_match || gc_match;
                        d.bc = bc_match;
                        d.gc = gc_match && !own_match;
                        d.lo_sent = 1'h0;
                        d.txsh = rd_word[15:8];
                        d.txlo = rd_word[7:0];
                        if (!(own_match || bc_match || gc_match)) begin
                            d.nxt = ST_SKIP;
                        end else if (own_match && q.sh[0]) begin
                            d.nxt = ST_TX;
                        end else begin
                            d.nxt = ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        if (q.gc) begin
                            // Only the reset code is taken after a general call
                            d.oe = (q.sh == GC_RST_BYTE);
                            d.nxt = ST_SKIP;
                        end else begin
                            d.oe = 1'h1;
                            d.cmd = q.sh;
                            d.cmd_seen = 1'h1;
                            d.nxt = ST_DHI;
                        end
                    end
                    ST_DHI: begin
                        d.oe = 1'h1;
                        d.hi = q.sh;
                        d.nxt = ST_DLO;
                    end
                    ST_DLO: begin
                        // Bytes past the lower one are refused
                        d.oe = 1'h1;
                        d.nxt = ST_SKIP;
                    end
                    ST_TX: begin
                        // Let go so the controller can answer
                        d.oe = 1'h0;
                        d.nxt = ST_TX;
                    end
                    ST_IDLE, ST_SKIP: begin
                        d.oe = 1'h0;
                    end
                endcase
            end else if (q.bitc == BIT_ACK) begin
                // Fall that closes the ninth clock
                d.bitc = BIT_FIRST;
                d.oe = 1'h0;
                d.st = q.nxt;
                if (q.st == ST_ADDR && q.nxt == ST_TX) begin
                    // Upper byte goes out first, driven right after this fall
                    d.oe = !q.txsh[7];
                end
                if (q.st == ST_DLO) begin
                    // Both bytes are in: apply on this very edge
                    d.upd = 1'h1;
                    d.last_wr = q.cmd;
                    case (q.cmd)
                        CMD_OPER: d.regs.oper = wr_word;
                        CMD_CODE: d.regs.code = wr_word;
                        CMD_MHI: d.regs.mhi = wr_word;
                        CMD_MLO: d.regs.mlo = wr_word;
                        CMD_MAIN: d.regs.main = wr_word;
                        CMD_SEC: begin
                            // Address assignment only lands where the pin is high
                            if (!pin_gate) begin
                                d.regs.sec = wr_word;
                            end
                        end
                        CMD_ACT: d.regs.act = wr_word;
                        default: begin
                            // Read-only or unknown target: nothing stored
                            d.upd = 1'h0;
                            d.last_wr = q.last_wr;
                        end
                    endcase
                end
                if (q.st == ST_TX) begin
                    if (q.mack && !q.lo_sent) begin
                        // Controller took the upper byte: send the lower one
                        d.lo_sent = 1'h1;
                        d.txsh = q.txlo;
                        d.oe = !q.txlo[7];
                    end else begin
                        // Not-acknowledge or both bytes done: stay off the line
                        d.st = ST_SKIP;
                    end
                end
            end else begin
                // Mid-byte fall: next bit position
                d.bitc = q.bitc + BIT_STEP;
                if (q.st == ST_TX) begin
                    d.txsh = {q.txsh[6:0], 1'h0};
                    d.oe = !q.txsh[6];
                end
            end
        end
    end

    // Engine state register
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register; data pin only ever pulls low
    assign SDA_O = q.sda_p && 1'h0;
    assign SDA_OE_O = q.oe;
    assign REGS_O = q.regs;
    assign UPDATE_O = q.upd;
    assign SW_RESET_O = q.swrst;

    // Checks on the engine
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    idle_release_a: assert property (q.st == ST_IDLE |-> !SDA_OE_O)
        else $error("line driven while idle");

    stop_idle_a: assert property (stop_seen |=> q.st == ST_IDLE && !SDA_OE_O)
        else $error("stop did not return to idle");

    skip_quiet_a: assert property (q.st == ST_SKIP |-> !SDA_OE_O)
        else $error("line driven while ignoring traffic");

    ack_hold_a: assert property (
        (q.oe && q.bitc == BIT_ACK && q.st != ST_TX && !scl_fall && !start_seen && !stop_seen)
        |=> q.oe)
        else $error("acknowledge released before the clock fell");

    update_edge_a: assert property (
        UPDATE_O |-> $past(scl_fall) && $past(q.st) == ST_DLO && $past(q.bitc) == BIT_ACK)
        else $error("update not on the fall ending the lower-byte acknowledge");

    reset_edge_a: assert property (
        SW_RESET_O |-> $past(scl_rise) && $past(q.gc) && REGS_O == REGS_RST)
        else $error("software reset at the wrong edge");

    bcast_read_a: assert property (q.st == ST_TX |-> !q.bc)
        else $error("read answered on broadcast address");

    addr_match_a: assert property (
        (q.st == ST_ADDR && q.bitc == BIT_ACK && q.oe && !q.bc && !q.gc)
        |-> q.sh[7:1] == {ADDR_FIXED, q.regs.sec[SEC_TADDR_HI:SEC_TADDR_LO]})
        else $error("acknowledged a foreign address");

    tx_order_a: assert property (
        (q.st != ST_TX ##1 q.st == ST_TX) |-> !q.lo_sent)
        else $error("read did not start with the upper byte");

    // Event pulses, register stability and transmit checks
    upd_pulse_a: assert property (UPDATE_O |=> !UPDATE_O)
        else $error("update pulse longer than one cycle");

    rst_pulse_a: assert property (SW_RESET_O |=> !SW_RESET_O)
        else $error("reset pulse longer than one cycle");

    regs_hold_a: assert property ((!UPDATE_O && !SW_RESET_O) |-> $stable(REGS_O))
        else $error("registers changed without an update");

    ro_store_a: assert property (
        UPDATE_O |-> q.last_wr != CMD_FLAGS && q.last_wr != CMD_PSTAT && q.last_wr != CMD_PREV)
        else $error("update reported for a read-only word");

    tx_release_a: assert property ((q.st == ST_TX && q.bitc == BIT_ACK) |-> !SDA_OE_O)
        else $error("line driven during the controller answer");

    foreign_nack_a: assert property (
        (q.st == ST_ADDR && q.bitc == BIT_ACK && q.nxt == ST_SKIP) |-> !SDA_OE_O)
        else $error("foreign address acknowledged");

    gc_code_a: assert property (
        (q.gc && q.st == ST_CMD && q.bitc == BIT_ACK && SDA_OE_O) |-> q.sh == GC_RST_BYTE)
        else $error("general call answered for a wrong code");

    ack_slot_a: assert property ((SDA_OE_O && q.st != ST_TX) |-> q.bitc == BIT_ACK)
        else $error("line driven outside an acknowledge slot");

    tx_bit_a: assert property (
        (q.st == ST_TX && q.bitc != BIT_ACK) |-> SDA_OE_O == !q.txsh[7])
        else $error("transmitted bit differs from the shift register");

endmodule

/* File: verif/dti_ctrl_model.sv */
// Behavioural bus controller: drives the bus clock and pulls the data line low
`timescale 1ns/100ps
module dti_ctrl_model (
    // System clock for pacing
    input wire logic clk_i,
    // Data line as seen on the wire
    input wire logic sda_i,
    // Bus clock and data pull-down
    output logic scl_o,
    output logic sda_oe_o
);
    // Half of one clock phase in system cycles; a 40-cycle period keeps the bus at 1 MHz
    localparam int HALF = 10;

    // Idle bus: clock high, data released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // Pacing; moves only on falling edges of the system clock
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Start, or repeated start from a low clock
    task automatic bus_start();
        wt(4);
        sda_oe_o = 1'b0;
        wt(2 * HALF);
        scl_o = 1'b1;
        wt(2 * HALF);
        sda_oe_o = 1'b1;
        wt(2 * HALF);
        scl_o = 1'b0;
    endtask

    // Stop: data rises while the clock is high
    task automatic bus_stop();
        wt(4);
        sda_oe_o = 1'b1;
        wt(2 * HALF);
        scl_o = 1'b1;
        wt(2 * HALF);
        sda_oe_o = 1'b0;
        wt(2 * HALF);
    endtask

    // One clock; data moves a few cycles after the fall so no false start or stop is seen
    task automatic clock_bit(input logic pull, output logic mid, output logic late);
        wt(4);
        sda_oe_o = pull;
        wt(2 * HALF - 4);
        scl_o = 1'b1;
        wt(HALF);
        mid = sda_i;
        wt(HALF);
        late = sda_i;
        scl_o = 1'b0;
    endtask

    // Byte out, MSB first; ack only if low at both the mid and the late sample of the high phase
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic m;
        logic l;
        for (int i = 7; i >= 0; i--) clock_bit(~b[i], m, l);
        clock_bit(1'b0, m, l);
        ack = ~m & ~l;
    endtask

    // Byte in, MSB first, then our own ack or not-ack
    task automatic get_byte(output logic [7:0] b, input logic give_ack);
        logic m;
        for (int i = 7; i >= 0; i--) clock_bit(1'b0, m, b[i]);
        clock_bit(give_ack, m, m);
    endtask
endmodule

/* File: verif/dti_target_bench.sv */
// Self-checking bench for the serial target engine
`timescale 1ns/100ps
module dti_target_bench;
    import dti_pkg::*;

    // Clock, reset and pins
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic gpin = 1'b0;
    wire scl;
    wire sda;
    logic m_oe;
    logic dut_oe;
    logic dut_sd;
    // Arbitrary read-only words
    dti_ro_type ro = '{flags: 16'h5A01, stat_sum: 16'h0042, revision: 16'h0022};
    dti_regs_type regs;
    logic upd;
    logic swr;
    // Monitor state and tallies
    int scl_cnt = 0;
    int upd_n = 0;
    int upd_at = 0;
    logic upd_lo = 1'b1;
    int rst_n = 0;
    logic oe_seen = 1'b0;
    int err_total = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;
    // Open-drain data line with pull-up
    assign sda = ~((dut_oe & ~dut_sd) | m_oe);

    dti_target dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(dut_sd),
        .SDA_OE_O(dut_oe), .GENERAL_INPUT_PIN_I(gpin), .READBACK_I(ro), .REGS_O(regs),
        .UPDATE_O(upd), .SW_RESET_O(swr));
    dti_ctrl_model ctrl_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

    // Bus clock rises counted from each start
    always @(posedge scl) scl_cnt = scl_cnt + 1;
    always @(negedge sda) if (scl === 1'b1) scl_cnt = 0;
    // Pulses and any data drive by the target, sampled mid-cycle away from the launch edge
    always @(negedge clk) begin
        if (upd === 1'b1) begin
            upd_n = upd_n + 1;
            upd_at = scl_cnt;
            upd_lo = scl;
        end
        if (swr === 1'b1) rst_n = rst_n + 1;
        if (dut_oe === 1'b1) oe_seen = 1'b1;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    // Full write frame; k holds address, command, upper and lower acks
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
        output logic [3:0] k);
        ctrl_u.bus_start();
        ctrl_u.put_byte({a, 1'b0}, k[3]);
        ctrl_u.put_byte(c, k[2]);
        ctrl_u.put_byte(w[15:8], k[1]);
        ctrl_u.put_byte(w[7:0], k[0]);
        ctrl_u.bus_stop();
    endtask
    // Command read through repeated start
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] c, output logic [15:0] w,
        output logic [2:0] k);
        ctrl_u.bus_start();
        ctrl_u.put_byte({a, 1'b0}, k[2]);
        ctrl_u.put_byte(c, k[1]);
        ctrl_u.bus_start();
        ctrl_u.put_byte({a, 1'b1}, k[0]);
        ctrl_u.get_byte(w[15:8], 1'b1);
        ctrl_u.get_byte(w[7:0], 1'b0);
        ctrl_u.bus_stop();
    endtask
    // Read with no command; bytes fetched only when answered
    task automatic rd_last(input logic [6:0] a, output logic [15:0] w, output logic k);
        ctrl_u.bus_start();
        ctrl_u.put_byte({a, 1'b1}, k);
        if (k === 1'b1) begin
            ctrl_u.get_byte(w[15:8], 1'b1);
            ctrl_u.get_byte(w[7:0], 1'b0);
        end
        ctrl_u.bus_stop();
    endtask

    task automatic t_write();
        logic [3:0] k;
        upd_n = 0;
        wr_reg(7'h48, CMD_CODE, 16'hA5C3, k);
        chk16(16'(k), 16'h000F, "write acks");
        chk16(regs.code, 16'hA5C3, "code value");
        chk16(16'(upd_n), 16'h0001, "one update");
        chk16(16'(upd_at), 16'h0024, "clocks before update");
        chk1(upd_lo, 1'b0, "update after clock fall");
        chk1(dut_oe, 1'b0, "released after stop");
        $display("test write done");
    endtask

    task automatic t_partial();
        logic a;
        upd_n = 0;
        ctrl_u.bus_start();
        ctrl_u.put_byte(8'h90, a);
        ctrl_u.put_byte(CMD_CODE, a);
        ctrl_u.put_byte(8'h11, a);
        ctrl_u.bus_stop();
        chk16(regs.code, 16'hA5C3, "upper byte alone");
        chk16(16'(upd_n), 16'h0000, "no update");
        $display("test partial done");
    endtask

    task automatic t_map();
        logic [7:0] wc [6];
        logic [7:0] rc [3];
        logic [15:0] re [3];
        logic [15:0] w;
        logic [3:0] k;
        logic [2:0] kk;
        wc = '{CMD_OPER, CMD_CODE, CMD_MHI, CMD_MLO, CMD_MAIN, CMD_ACT};
        rc = '{CMD_FLAGS, CMD_PSTAT, CMD_PREV};
        re = '{ro.flags, ro.stat_sum, ro.revision};
        for (int i = 0; i < 6; i++) begin
            wr_reg(7'h48, wc[i], {wc[i], ~wc[i]}, k);
            rd_reg(7'h48, wc[i], w, kk);
            chk16(w, {wc[i], ~wc[i]}, "writable readback");
            chk16(16'(kk), 16'h0007, "read acks");
        end
        upd_n = 0;
        for (int i = 0; i < 3; i++) begin
            wr_reg(7'h48, rc[i], 16'hFFFF, k);
            rd_reg(7'h48, rc[i], w, kk);
            chk16(w, re[i], "read-only word");
        end
        chk16(16'(upd_n), 16'h0000, "read-only not stored");
        $display("test map done");
    endtask

    task automatic t_addr();
        logic [15:0] w;
        logic [3:0] k;
        logic a;
        for (int s = 0; s < 4; s++) begin
            wr_reg(ADDR_BCAST, CMD_SEC, {s[1:0], 14'h0000}, k);
            chk16(16'(k), 16'h000F, "broadcast acks");
            rd_last({ADDR_FIXED, s[1:0]}, w, a);
            chk1(a, 1'b1, "own address");
            chk16(w, {s[1:0], 14'h0000}, "last written");
            oe_seen = 1'b0;
            rd_last({ADDR_FIXED, s[1:0] + 2'h1}, w, a);
            rd_last({5'h13, s[1:0]}, w, a);
            chk1(oe_seen, 1'b0, "foreign address ignored");
        end
        wr_reg(ADDR_BCAST, CMD_SEC, 16'h0000, k);
        $display("test address done");
    endtask

    task automatic t_refuse();
        logic [15:0] w;
        logic [3:0] k;
        logic a;
        oe_seen = 1'b0;
        rd_last(ADDR_BCAST, w, a);
        wr_reg(7'h78, CMD_CODE, 16'h0000, k);
        chk1(oe_seen, 1'b0, "broadcast read and ten-bit ignored");
        chk16(regs.code, {CMD_CODE, ~CMD_CODE}, "code kept");
        $display("test refuse done");
    endtask

    task automatic t_gated();
        logic [15:0] w;
        logic [3:0] k;
        logic a;
        wr_reg(ADDR_BCAST, CMD_SEC, 16'h3800, k);
        wr_reg(ADDR_BCAST, CMD_ACT, 16'h0400, k);
        wr_reg(ADDR_BCAST, CMD_SEC, 16'h7800, k);
        chk16(regs.sec, 16'h3800, "pin low skips");
        gpin = 1'b1;
        wr_reg(ADDR_BCAST, CMD_SEC, 16'h7800, k);
        chk16(regs.sec, 16'h7800, "pin high takes");
        gpin = 1'b0;
        rd_last(7'h49, w, a);
        chk1(a, 1'b1, "assigned address");
        wr_reg(ADDR_BCAST, CMD_ACT, 16'h0000, k);
        wr_reg(ADDR_BCAST, CMD_SEC, 16'h0000, k);
        chk16(regs.sec, 16'h0000, "function cleared");
        $display("test gated done");
    endtask

    task automatic t_gcall();
        logic a;
        rst_n = 0;
        ctrl_u.bus_start();
        ctrl_u.put_byte(8'h00, a);
        chk16(16'(rst_n), 16'h0000, "no reset yet");
        ctrl_u.put_byte(GC_RST_BYTE, a);
        chk1(a, 1'b1, "reset byte answered");
        chk16(16'(rst_n), 16'h0001, "reset pulse");
        ctrl_u.bus_stop();
        chk16(regs.code, 16'h0000, "registers cleared");
        $display("test general call done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        chk1(regs === '0, 1'b1, "registers at reset");
        chk1(dut_oe | upd | swr, 1'b0, "outputs at reset");
        @(negedge clk);
        arst_n = 1'b1;
        repeat (5) @(negedge clk);
        t_write();
        t_partial();
        t_map();
        t_addr();
        t_refuse();
        t_gated();
        t_gcall();
        final_report();
    end

    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule
